// ### design/mpats_defs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef MPATS_DEFS_SVH
`define MPATS_DEFS_SVH
`define MPATS_A_CTRL    8'h00
`define MPATS_A_INIT    8'h04
`define MPATS_A_MOD     8'h08
`define MPATS_A_DUTY0   8'h0c
`define MPATS_A_DUTY1   8'h10
`define MPATS_A_DUTY2   8'h14
`define MPATS_A_DEAD    8'h18
`define MPATS_A_PT0     8'h1c
`define MPATS_A_DMOD    8'h20
`define MPATS_A_IDLY    8'h24
`define MPATS_A_STAT    8'h28
`define MPATS_A_SMOD    8'h2c
`define MPATS_A_MASK    8'h30
`define MPATS_A_DAC     8'h34
`define MPATS_B_PWM_EN  0
`define MPATS_B_TRIG_EN 1
`define MPATS_B_POL_HI  2
`define MPATS_B_POL_LO  3
`define MPATS_B_B2B     4
`define MPATS_B_FLT_A   5
`define MPATS_B_FLT_B   6
`define MPATS_B_FLT_CMP 7
`define MPATS_B_FLT_LOW 8
`define MPATS_B_CAL     9
`define MPATS_B_DLY_EN  10
`define MPATS_B_SLOW_EN 11
`define MPATS_R_CTRL    12'hcb2
`define MPATS_R_INIT    16'hf15a
`define MPATS_R_MOD     16'h0ea5
`define MPATS_R_DMOD    16'h1387
`define MPATS_R_IDLY    16'h0ea6
`define MPATS_R_SMOD    16'h124f
`define MPATS_R_MASK    8'hc0
`define MPATS_R_DAC     6'h3e
`define MPATS_CLK_MHZ   250
`define MPATS_BUS_DIV   3
`define MPATS_SLOW_DIV  16
`define MPATS_FILT_N    4
`define MPATS_DEAD_NS   500
`define MPATS_PT0_NS    250
`define MPATS_DEAD_CYC  ((`MPATS_DEAD_NS * `MPATS_CLK_MHZ) / 1000)
`define MPATS_PT0_TICKS ((`MPATS_PT0_NS * `MPATS_CLK_MHZ) / (1000 * `MPATS_BUS_DIV))
`endif

// ### design/mpats_pkg.sv
// Types shared by the motor PWM block
`default_nettype none
package mpats_pkg;
   typedef enum logic [1:0] {
      MPATS_DLY_IDLE = 2'b00,
      MPATS_DLY_RUN  = 2'b01
   } mpats_dly_t;
   typedef logic signed [15:0] mpats_cnt_t;
   typedef struct packed {
      logic             ack;
      logic [31:0]      rdat;
      logic [11:0]      ctrl;
      mpats_cnt_t       init;
      mpats_cnt_t       modv;
      logic [2:0][15:0] duty;
      logic [15:0]      dead;
      logic [15:0]      pt0;
      logic [15:0]      dmod;
      logic [15:0]      idly;
      logic [15:0]      smod;
      logic [7:0]       mask;
      logic [5:0]       dac;
      mpats_cnt_t       cnt;
      logic             trig;
      logic [2:0]       dis;
      logic [2:0]       raw;
      logic [2:0][15:0] dt;
      logic [5:0]       pwm;
      logic [1:0]       bdiv;
      mpats_dly_t       dst;
      logic [15:0]      dcnt;
      logic [1:0]       pend;
      logic [1:0]       pt0o;
      logic [1:0]       pt1o;
      logic [1:0][1:0]  unread;
      logic             dly_f;
      logic             err_f;
      logic             fast_f;
      logic             dly_irq;
   } mpats_state_t;
endpackage : mpats_pkg
`default_nettype wire

// ### design/mpats_in_filter.sv
// Pin synchroniser with an N-sample agreement filter
`default_nettype none
module mpats_in_filter #(
   parameter int N = 4
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic raw_i,
   output logic      flt_o
);
   typedef struct packed {
      logic         s1;
      logic         s2;
      logic [N-1:0] hist;
      logic         out;
   } mpats_flt_t;
   mpats_flt_t s;
   mpats_flt_t n;

   if (N < 1 || N > 16) begin : g_bad
      $error("mpats_in_filter: N must be 1 to 16");
   end

   // Two-stage sync, history shift, output moves only on full agreement
   always_comb begin
      n = s;
      n.s1 = raw_i;
      n.s2 = s.s1;
      n.hist = N'({s.hist, s.s2});
      if (s.hist == {N{1'b1}}) begin
         n.out = 1'b1;
      end else if (s.hist == {N{1'b0}}) begin
         n.out = 1'b0;
      end
      if (rst_i) begin
         n = '0;
      end
   end

   // State register
   always_ff @(posedge clk_i) begin
      s <= n;
   end

   assign flt_o = s.out;

   chk_filt_agree: assert property (@(posedge clk_i) disable iff (rst_i)
      $changed(s.out) |-> $past(s.hist) == {N{s.out}}) else $error("filter output moved without agreement");
endmodule : mpats_in_filter
`default_nettype wire

// ### design/mpats_slow_timer.sv
// Slow-loop timer on a divided clock enable with reload pulse
`default_nettype none
module mpats_slow_timer #(
   parameter int W   = 16,
   parameter int DIV = 16
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         en_i,
   input  wire logic [W-1:0] mod_i,
   output logic              irq_o
);
   typedef struct packed {
      logic [4:0]   div;
      logic [W-1:0] cnt;
      logic         irq;
   } mpats_slow_t;
   mpats_slow_t s;
   mpats_slow_t n;
   logic        tick;

   if (DIV < 2 || DIV > 32 || W < 2) begin : g_bad
      $error("mpats_slow_timer: DIV must be 2 to 32, W at least 2");
   end

   // Count on every DIV-th clock from zero to modulo, pulse at reload
   always_comb begin
      n = s;
      n.irq = 1'b0;
      tick = (s.div == 5'(DIV - 1));
      n.div = tick ? 5'h00 : s.div + 5'h01;
      if (!en_i) begin
         n.cnt = '0;
      end else if (tick) begin
         if (s.cnt >= mod_i) begin
            n.cnt = '0;
            n.irq = 1'b1;
         end else begin
            n.cnt = s.cnt + W'(1);
         end
      end
      if (rst_i) begin
         n = '0;
      end
   end

   // State register
   always_ff @(posedge clk_i) begin
      s <= n;
   end

   assign irq_o = s.irq;

   chk_slow_reload: assert property (@(posedge clk_i) disable iff (rst_i)
      irq_o |-> s.cnt == '0 && $past(s.cnt) >= $past(mod_i) && $past(tick)) else $error("slow irq without reload");
endmodule : mpats_slow_timer
`default_nettype wire

// ### design/mpats_top.sv
// Motor PWM generator, trigger delay unit, fault path and slow-loop timer
// Overview of operation
// - Six channels form pairs 0+1, 2+3, 4+5, each pair complementary.
// - Only six channels drive pins; mask bits of channels 6 and 7 stay set.
// - Fault disables each pair; outputs return at first reload after fault clears.
// - Counter runs from initial value -3750 to modulo 3749, then reloads.
// - Each pair inserts programmable dead time between its two outputs.
// - Reload emits a trigger; when enabled it restarts the delay counter.
// - Pre-trigger 0 on both ADC channels a programmed delay after the trigger.
// - In back-to-back mode pre-trigger 1 follows first conversion complete at once.
// - ADCs start only on pre-triggers; first conversion raises fast-loop interrupt.
// - Delay interrupt at programmed count; its handler re-enables the trigger.
// - Delay modulo fixes the PWM to control-loop rate ratio, two by default.
// - Delay interrupt yields to the conversion-complete interrupt.
// - Sequence error when a pre-trigger hits an unread result slot.
// - Sequence error and delay events share one interrupt line and flag word.
// - Delay unit counts on a bus tick of one third the count clock.
// - Calibration selects slow ADC clock, continuous mode, 32-sample averaging.
// - Over-current comparator uses 6-bit threshold reference, default 62 of 64.
// - Comparator filter changes only after four agreeing samples.
// - Slow-loop timer counts on clock over 16 and pulses at reload.
// - High-side and low-side polarity selectable independently.
//
// Design decisions made here: the placing of the registers and the Wishbone register port.
`default_nettype none
`include "mpats_defs.svh"
module mpats_top
   import mpats_pkg::*;
(
   input  wire logic        MCLK_I,
   input  wire logic        RST_I,
   input  wire logic [7:2]  ADR_I,
   input  wire logic [31:0] DAT_I,
   input  wire logic [3:0]  SEL_I,
   input  wire logic        WE_I,
   input  wire logic        CYC_I,
   input  wire logic        STB_I,
   output logic [31:0]      DAT_O,
   output logic             ACK_O,
   input  wire logic        FAULT_A_I,
   input  wire logic        FAULT_B_I,
   input  wire logic        CMP_OUT_I,
   input  wire logic [1:0]  ADC_COCO_I,
   input  wire logic [3:0]  ADC_RD_I,
   output logic [5:0]       PWM_O,
   output logic             TRIG_O,
   output logic [1:0]       ADC_PT0_O,
   output logic [1:0]       ADC_PT1_O,
   output logic             FAST_IRQ_O,
   output logic             DLY_IRQ_O,
   output logic             SLOW_IRQ_O,
   output logic [5:0]       DAC_CODE_O,
   output logic             ADC_CAL_O
);
   mpats_state_t s;
   mpats_state_t n;
   logic         flt_a;
   logic         flt_b;
   logic         cmp_f;
   logic         fault;
   logic         hit;
   logic         wr;
   logic [7:0]   adr;
   logic [31:0]  rd;
   logic         reload;
   logic         start;
   logic         btick;
   logic         en;
   logic         on;
   mpats_cnt_t   dty;

   // Fault pins pass a plain synchroniser, comparator gets the 4-sample filter
   mpats_in_filter #(.N(1)) u_flt_a (
      .clk_i (MCLK_I),
      .rst_i (RST_I),
      .raw_i (FAULT_A_I),
      .flt_o (flt_a)
   );
   mpats_in_filter #(.N(1)) u_flt_b (
      .clk_i (MCLK_I),
      .rst_i (RST_I),
      .raw_i (FAULT_B_I),
      .flt_o (flt_b)
   );
   mpats_in_filter #(.N(`MPATS_FILT_N)) u_cmp (
      .clk_i (MCLK_I),
      .rst_i (RST_I),
      .raw_i (CMP_OUT_I),
      .flt_o (cmp_f)
   );

   // Slow-loop timer
   mpats_slow_timer #(.W(16), .DIV(`MPATS_SLOW_DIV)) u_slow (
      .clk_i (MCLK_I),
      .rst_i (RST_I),
      .en_i  (s.ctrl[`MPATS_B_SLOW_EN]),
      .mod_i (s.smod),
      .irq_o (SLOW_IRQ_O)
   );

   // Byte-lane merge of a bus write into an old register value
   function automatic logic [31:0] bm(input logic [31:0] o);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (SEL_I[i]) begin
            r[8*i+:8] = DAT_I[8*i+:8];
         end
      end
      return r;
   endfunction : bm

   // Active fault from enabled sources, pin polarity selectable
   assign fault = (s.ctrl[`MPATS_B_FLT_A] & (flt_a ^ s.ctrl[`MPATS_B_FLT_LOW]))
                | (s.ctrl[`MPATS_B_FLT_B] & (flt_b ^ s.ctrl[`MPATS_B_FLT_LOW]))
                | (s.ctrl[`MPATS_B_FLT_CMP] & cmp_f);

   // Register read multiplexer
   always_comb begin
      adr = {ADR_I, 2'b00};
      case (adr)
         `MPATS_A_CTRL:  rd = {20'h00000, s.ctrl};
         `MPATS_A_INIT:  rd = {16'h0000, s.init};
         `MPATS_A_MOD:   rd = {16'h0000, s.modv};
         `MPATS_A_DUTY0: rd = {16'h0000, s.duty[0]};
         `MPATS_A_DUTY1: rd = {16'h0000, s.duty[1]};
         `MPATS_A_DUTY2: rd = {16'h0000, s.duty[2]};
         `MPATS_A_DEAD:  rd = {16'h0000, s.dead};
         `MPATS_A_PT0:   rd = {16'h0000, s.pt0};
         `MPATS_A_DMOD:  rd = {16'h0000, s.dmod};
         `MPATS_A_IDLY:  rd = {16'h0000, s.idly};
         `MPATS_A_STAT:  rd = {25'h0000000, s.dis, fault, s.fast_f, s.err_f, s.dly_f};
         `MPATS_A_SMOD:  rd = {16'h0000, s.smod};
         `MPATS_A_MASK:  rd = {24'h000000, s.mask};
         `MPATS_A_DAC:   rd = {26'h0000000, s.dac};
         default:        rd = 32'h00000000;
      endcase
   end

   // Next-state logic: bus slave first, then hardware events so sets win
   always_comb begin
      n = s;
      dty = 16'sh0000;
      on = 1'b0;
      hit = CYC_I & STB_I;
      wr = hit & s.ack & WE_I;
      n.ack = hit & ~s.ack;
      if (hit & ~s.ack) begin
         n.rdat = rd;
      end
      if (wr) begin
         case (adr)
            `MPATS_A_CTRL:  n.ctrl = 12'(bm({20'h00000, s.ctrl}));
            `MPATS_A_INIT:  n.init = 16'(bm({16'h0000, s.init}));
            `MPATS_A_MOD:   n.modv = 16'(bm({16'h0000, s.modv}));
            `MPATS_A_DUTY0: n.duty[0] = 16'(bm({16'h0000, s.duty[0]}));
            `MPATS_A_DUTY1: n.duty[1] = 16'(bm({16'h0000, s.duty[1]}));
            `MPATS_A_DUTY2: n.duty[2] = 16'(bm({16'h0000, s.duty[2]}));
            `MPATS_A_DEAD:  n.dead = 16'(bm({16'h0000, s.dead}));
            `MPATS_A_PT0:   n.pt0 = 16'(bm({16'h0000, s.pt0}));
            `MPATS_A_DMOD:  n.dmod = 16'(bm({16'h0000, s.dmod}));
            `MPATS_A_IDLY:  n.idly = 16'(bm({16'h0000, s.idly}));
            `MPATS_A_SMOD:  n.smod = 16'(bm({16'h0000, s.smod}));
            `MPATS_A_MASK:  n.mask = 8'(bm({24'h000000, s.mask}));
            `MPATS_A_DAC:   n.dac = 6'(bm({26'h0000000, s.dac}));
            `MPATS_A_STAT: begin
               n.dly_f = s.dly_f & ~(SEL_I[0] & DAT_I[0]);
               n.err_f = s.err_f & ~(SEL_I[0] & DAT_I[1]);
               n.fast_f = s.fast_f & ~(SEL_I[0] & DAT_I[2]);
            end
            default: ;
         endcase
      end
      n.mask = n.mask | `MPATS_R_MASK;

      // PWM counter: signed initial value up to modulo, then reload
      en = s.ctrl[`MPATS_B_PWM_EN];
      reload = en && (s.cnt >= s.modv);
      start = reload && s.ctrl[`MPATS_B_TRIG_EN];
      n.trig = start;
      if (!en || reload) begin
         n.cnt = s.init;
      end else begin
         n.cnt = s.cnt + 16'sh0001;
      end

      // Per pair: centre-aligned compare, dead time, fault gating, polarity
      for (int p = 0; p < 3; p++) begin
         dty = mpats_cnt_t'(s.duty[p]);
         n.raw[p] = en && (s.cnt >= -dty) && (s.cnt < dty);
         if (n.raw[p] != s.raw[p]) begin
            n.dt[p] = 16'h0000;
         end else if (s.dt[p] < s.dead) begin
            n.dt[p] = s.dt[p] + 16'h0001;
         end
         on = (s.dt[p] >= s.dead) && en && !s.dis[p];
         n.pwm[2*p] = (s.raw[p] & on & ~s.mask[2*p]) ^ s.ctrl[`MPATS_B_POL_HI];
         n.pwm[2*p+1] = (~s.raw[p] & on & ~s.mask[2*p+1]) ^ s.ctrl[`MPATS_B_POL_LO];
         if (fault) begin
            n.dis[p] = 1'b1;
         end else if (reload) begin
            n.dis[p] = 1'b0;
         end
      end

      // Delay unit: bus tick at one third of the count clock
      btick = (s.bdiv == 2'(`MPATS_BUS_DIV - 1));
      n.bdiv = btick ? 2'b00 : s.bdiv + 2'b01;
      n.pt0o = 2'b00;
      n.pt1o = 2'b00;
      case (s.dst)
         MPATS_DLY_IDLE: ;
         MPATS_DLY_RUN: begin
            if (btick) begin
               if (s.dcnt == s.pt0) begin
                  n.pt0o = 2'b11;
                  n.pend = 2'b11;
                  if (s.unread[0][0] | s.unread[1][0]) begin
                     n.err_f = 1'b1;
                  end
               end
               if (s.dcnt == s.idly) begin
                  n.dly_f = 1'b1;
               end
               if (s.dcnt >= s.dmod) begin
                  n.dst = MPATS_DLY_IDLE;
               end else begin
                  n.dcnt = s.dcnt + 16'h0001;
               end
            end
         end
         default: n.dst = MPATS_DLY_IDLE;
      endcase

      // Conversion complete: back-to-back pre-trigger, result tracking
      for (int c = 0; c < 2; c++) begin
         if (ADC_RD_I[2*c]) begin
            n.unread[c][0] = 1'b0;
         end
         if (ADC_RD_I[2*c+1]) begin
            n.unread[c][1] = 1'b0;
         end
         if (ADC_COCO_I[c]) begin
            n.unread[c][s.pend[c] ? 0 : 1] = 1'b1;
            if (s.pend[c]) begin
               n.pend[c] = 1'b0;
               if (s.ctrl[`MPATS_B_B2B]) begin
                  n.pt1o[c] = 1'b1;
                  if (s.unread[c][1]) begin
                     n.err_f = 1'b1;
                  end
               end
            end
         end
      end
      if (ADC_COCO_I[0] && s.pend[0]) begin
         n.fast_f = 1'b1;
      end

      // Trigger restarts the delay counter
      if (start && s.ctrl[`MPATS_B_DLY_EN]) begin
         n.dst = MPATS_DLY_RUN;
         n.dcnt = 16'h0000;
         n.pend = 2'b00;
      end

      // Shared delay line, held off while the fast-loop event is pending
      n.dly_irq = (n.dly_f | n.err_f) & ~n.fast_f;

      if (RST_I) begin
         n = '0;
         n.ctrl = `MPATS_R_CTRL;
         n.init = `MPATS_R_INIT;
         n.modv = `MPATS_R_MOD;
         n.dead = 16'(`MPATS_DEAD_CYC);
         n.pt0 = 16'(`MPATS_PT0_TICKS);
         n.dmod = `MPATS_R_DMOD;
         n.idly = `MPATS_R_IDLY;
         n.smod = `MPATS_R_SMOD;
         n.mask = `MPATS_R_MASK;
         n.dac = `MPATS_R_DAC;
         n.cnt = `MPATS_R_INIT;
         n.dst = MPATS_DLY_IDLE;
      end
   end

   // State register
   always_ff @(posedge MCLK_I) begin
      s <= n;
   end

   // Outputs straight from state flops
   assign DAT_O = s.rdat;
   assign ACK_O = s.ack;
   assign PWM_O = s.pwm;
   assign TRIG_O = s.trig;
   assign ADC_PT0_O = s.pt0o;
   assign ADC_PT1_O = s.pt1o;
   assign FAST_IRQ_O = s.fast_f;
   assign DLY_IRQ_O = s.dly_irq;
   assign DAC_CODE_O = s.dac;
   assign ADC_CAL_O = s.ctrl[`MPATS_B_CAL];

   default clocking cb @(posedge MCLK_I);
   endclocking
   default disable iff (RST_I);

   // Checks on mask, counter, trigger, delay unit, interrupt priority and bus ack
   chk_mask_held: assert property (s.mask[7:6] == 2'b11) else $error("spare channel unmasked");
   chk_cnt_reload: assert property (reload |=> s.cnt == $past(s.init)) else $error("no reload to initial");
   chk_trig_pulse: assert property (start |=> TRIG_O ##1 !TRIG_O) else $error("trigger not a pulse");
   chk_dly_restart: assert property (start && s.ctrl[`MPATS_B_DLY_EN] |=>
      s.dst == MPATS_DLY_RUN && s.dcnt == 16'h0000) else $error("delay counter not restarted");
   chk_pt0_timing: assert property (btick && s.dst == MPATS_DLY_RUN && s.dcnt == s.pt0 |=>
      ADC_PT0_O == 2'b11) else $error("pre-trigger 0 missing");
   chk_b2b_pt1: assert property (ADC_COCO_I[0] && s.pend[0] && s.ctrl[`MPATS_B_B2B] |=>
      ADC_PT1_O[0]) else $error("pre-trigger 1 not immediate");
   chk_dly_flag: assert property (btick && s.dst == MPATS_DLY_RUN && s.dcnt == s.idly |=>
      s.dly_f) else $error("delay flag not set");
   chk_irq_prio: assert property (DLY_IRQ_O |-> !FAST_IRQ_O) else $error("delay irq over fast irq");
   chk_seq_error: assert property (ADC_PT0_O[0] && $past(s.unread[0][0]) |->
      s.err_f) else $error("sequence error missed");
   chk_bus_ack: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O ##1 !ACK_O) else $error("bad ack timing");

   // Per-pair output checks
   for (genvar p = 0; p < 3; p++) begin : g_chk
      chk_pair_excl: assert property ($past(s.ctrl[3:2]) == s.ctrl[3:2] |->
         !((PWM_O[2*p] ^ s.ctrl[`MPATS_B_POL_HI]) && (PWM_O[2*p+1] ^ s.ctrl[`MPATS_B_POL_LO])))
         else $error("pair both active");
      chk_dead_gap: assert property (s.dt[p] < s.dead |=>
         PWM_O[2*p+:2] == {$past(s.ctrl[`MPATS_B_POL_LO]), $past(s.ctrl[`MPATS_B_POL_HI])})
         else $error("dead time violated");
      chk_fault_off: assert property (fault |=> ##1
         PWM_O[2*p+:2] == {$past(s.ctrl[`MPATS_B_POL_LO]), $past(s.ctrl[`MPATS_B_POL_HI])})
         else $error("fault did not idle pair");
      chk_fault_recover: assert property (s.dis[p] && !fault && reload |=> !s.dis[p])
         else $error("pair not re-enabled at reload");
   end
endmodule : mpats_top
`default_nettype wire

// ### sim/mpats_gate_model.sv
// Gate driver and inverter leg model that watches for shoot-through on all three legs and for the leg 0 dead gap
`default_nettype none
module mpats_gate_model (
   input  wire logic       clk_i,
   input  wire logic [5:0] pwm_i,
   input  wire logic       pol_hi_i,
   input  wire logic       pol_lo_i,
   output logic            shoot_o,
   output int              gap_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] on;
   logic       shoot = 1'b0;
   int         gap = 0;
   int         idle = 0;
   // A switch conducts when its pin sits at the active level
   assign on = pwm_i ^ {3{pol_lo_i, pol_hi_i}};
   assign shoot_o = shoot;
   assign gap_o = gap;
   // Both switches of one leg on would short the bus; leg 0 gap is kept at each turn-on
   always @(posedge clk_i) begin
      if ((on[0] & on[1]) | (on[2] & on[3]) | (on[4] & on[5])) begin
         shoot <= 1'b1;
      end
      if (on[1:0] == 2'b00) begin
         idle <= idle + 1;
      end else begin
         if (idle != 0) begin
            gap <= idle;
         end
         idle <= 0;
      end
   end
endmodule : mpats_gate_model
`default_nettype wire

// ### sim/motor_pwm_adc_trigger_sync_test.sv
// Self-checking bench for the motor PWM and trigger delay block
`default_nettype none
`include "mpats_defs.svh"
module motor_pwm_adc_trigger_sync_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic [7:2]  adr = '0;
   logic [31:0] dat_w = '0;
   logic        we = 1'b0;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        flt_a = 1'b0;
   logic        flt_b = 1'b1;
   logic        pol_hi = 1'b0;
   logic        pol_lo = 1'b0;
   logic        cmp = 1'b0;
   logic [1:0]  coco = '0;
   logic [3:0]  rd = '0;
   logic [31:0] dat_r, q;
   logic        ack, trig, fast_irq, dly_irq, slow_irq, cal, shoot;
   logic [5:0]  pwm, dac;
   logic [1:0]  pt0, pt1;
   int          gap, n;
   int          err_count = 0;
   int          total_checks = 0;
   int          cycles = 0;
   mpats_top i_dut (.MCLK_I(mclk), .RST_I(rst), .ADR_I(adr), .DAT_I(dat_w), .SEL_I(4'hf), .WE_I(we),
      .CYC_I(cyc), .STB_I(stb), .DAT_O(dat_r), .ACK_O(ack), .FAULT_A_I(flt_a), .FAULT_B_I(flt_b),
      .CMP_OUT_I(cmp), .ADC_COCO_I(coco), .ADC_RD_I(rd), .PWM_O(pwm), .TRIG_O(trig), .ADC_PT0_O(pt0),
      .ADC_PT1_O(pt1), .FAST_IRQ_O(fast_irq), .DLY_IRQ_O(dly_irq), .SLOW_IRQ_O(slow_irq),
      .DAC_CODE_O(dac), .ADC_CAL_O(cal));
   mpats_gate_model i_gate (.clk_i(mclk), .pwm_i(pwm), .pol_hi_i(pol_hi), .pol_lo_i(pol_lo), .shoot_o(shoot),
      .gap_o(gap));
   // Clock and hang guard
   always #2 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 90000) begin
         err_count++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // Classic Wishbone single cycle, held until ack is sampled
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      adr <= a[7:2];
      we <= w;
      dat_w <= d;
      do @(posedge mclk); while (ack !== 1'b1);
      q = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb
   task automatic idle(input int k);
      repeat (k) @(posedge mclk);
   endtask : idle
   task automatic wtrig();
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (trig !== 1'b1);
   endtask : wtrig
   task automatic clear_flags();
      rd <= 4'hf;
      idle(1);
      rd <= 4'h0;
      wb(`MPATS_A_STAT, 1'b1, 32'h7);
   endtask : clear_flags
   task automatic t_slow();
      wb(`MPATS_A_SMOD, 1'b1, 32'h9);
      do @(posedge mclk); while (slow_irq !== 1'b1);
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (slow_irq !== 1'b1);
      chk("slow period", 32'ha0, n);
      $display("done slow timer");
   endtask : t_slow
   task automatic t_regs();
      logic [7:0]  ra [10] = '{8'h00, 8'h04, 8'h08, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h30, 8'h34, 8'h3c};
      logic [15:0] rv [10] = '{16'hcb2, 16'hf15a, 16'h0ea5, 16'h007d, 16'h0014, 16'h1387, 16'h0ea6,
                               16'h00c0, 16'h003e, 16'h0000};
      chk("dac pins", 32'h3e, dac);
      for (int i = 0; i < 10; i++) begin
         wb(ra[i], 1'b0, 32'h0);
         chk("reset value", {16'h0, rv[i]}, q);
      end
      wb(`MPATS_A_MASK, 1'b1, 32'h0);
      wb(`MPATS_A_MASK, 1'b0, 32'h0);
      chk("mask kept", 32'hc0, q);
      wb(`MPATS_A_DAC, 1'b1, 32'h20);
      idle(1);
      chk("dac write", 32'h20, dac);
      wb(`MPATS_A_DAC, 1'b1, 32'h3e);
      wb(`MPATS_A_CTRL, 1'b1, 32'heb2);
      idle(1);
      chk("cal on", 32'h1, cal);
      wb(`MPATS_A_CTRL, 1'b1, 32'hcb2);
      idle(1);
      chk("cal off", 32'h0, cal);
      $display("done registers");
   endtask : t_regs
   task automatic t_pwm();
      for (int i = 0; i < 3; i++) begin
         wb(8'h0c + 8'(4 * i), 1'b1, 32'h0);
      end
      wb(`MPATS_A_CTRL, 1'b1, 32'hcb3);
      wtrig();
      wtrig();
      chk("pwm period", 32'h1d4c, n);
      idle(200);
      chk("pair levels", 32'h2a, pwm);
      wb(`MPATS_A_DUTY0, 1'b1, 32'h3e8);
      idle(5200);
      chk("dead gap", 32'h7d, gap);
      chk("shoot through", 32'h0, shoot);
      wb(`MPATS_A_DUTY0, 1'b1, 32'h0);
      $display("done pwm");
   endtask : t_pwm
   task automatic t_adc();
      clear_flags();
      wtrig();
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pt0 !== 2'b11);
      chk("pt0 delay", 32'h1, (n >= 60 && n <= 66));
      coco <= 2'b01;
      idle(1);
      coco <= 2'b00;
      idle(1);
      chk("pt1 b2b", 32'h1, pt1);
      chk("fast irq", 32'h1, fast_irq);
      wb(`MPATS_A_CTRL, 1'b1, 32'hcb1);
      n = 0;
      repeat (11500) begin
         @(posedge mclk);
         n += (trig === 1'b1);
      end
      chk("no reload trigger", 32'h0, n);
      wb(`MPATS_A_STAT, 1'b0, 32'h0);
      chk("delay flag", 32'h5, q & 32'h7);
      chk("delay masked", 32'h0, dly_irq);
      wb(`MPATS_A_STAT, 1'b1, 32'h4);
      idle(2);
      chk("delay irq", 32'h1, dly_irq);
      wb(`MPATS_A_STAT, 1'b1, 32'h1);
      wb(`MPATS_A_CTRL, 1'b1, 32'hcb3);
      wtrig();
      idle(80);
      wb(`MPATS_A_STAT, 1'b0, 32'h0);
      chk("seq error", 32'h2, q & 32'h7);
      chk("shared irq", 32'h1, dly_irq);
      clear_flags();
      $display("done delay unit");
   endtask : t_adc
   task automatic t_fault();
      wtrig();
      idle(200);
      cmp <= 1'b1;
      idle(3);
      cmp <= 1'b0;
      idle(12);
      chk("cmp glitch", 32'h2a, pwm);
      flt_a <= 1'b1;
      idle(8);
      chk("fault off", 32'h0, pwm);
      flt_a <= 1'b0;
      idle(12);
      chk("fault held", 32'h0, pwm);
      wtrig();
      idle(200);
      chk("fault cleared", 32'h2a, pwm);
      cmp <= 1'b1;
      idle(12);
      chk("cmp fault", 32'h0, pwm);
      wb(`MPATS_A_CTRL, 1'b1, 32'hcb7);
      idle(1);
      pol_hi <= 1'b1;
      idle(3);
      chk("fault polarity", 32'h15, pwm);
      cmp <= 1'b0;
      wtrig();
      idle(200);
      chk("run polarity", 32'h3f, pwm);
      // Low sides active low, fault pin B active low
      wb(`MPATS_A_CTRL, 1'b1, 32'hd5b);
      idle(1);
      pol_hi <= 1'b0;
      pol_lo <= 1'b1;
      idle(3);
      chk("low polarity", 32'h00, pwm);
      flt_b <= 1'b0;
      idle(8);
      chk("fault b low", 32'h2a, pwm);
      chk("shoot through end", 32'h0, shoot);
      $display("done fault");
   endtask : t_fault
   // Main sequence
   initial begin
      idle(4);
      rst <= 1'b0;
      idle(2);
      t_slow();
      t_regs();
      t_pwm();
      t_adc();
      t_fault();
      give_verdict();
   end
endmodule : motor_pwm_adc_trigger_sync_test
`default_nettype wire
